// ===== hw/brownout_reset_control.sv
// Behaviour
// - Mode 01: software turns detection on or off with enable bit 13.
// - In software mode, enable set activates detection, cleared fully deactivates.
// - Enable bit acts only in software mode; elsewhere inert, reads 0.
// - Threshold always follows level configuration; no register write changes it.
// - While enabled, brown-out flag bit 1 sets on brown-out or power-on event.
// - Mode 10: hardware control, detection disabled automatically during Sleep.
// - Mode 10: detection re-enabled as soon as the device leaves Sleep.
`timescale 1ns/1ps
module brownout_reset_control (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [1:0]  brownout_mode_cfg,
  input  wire logic [1:0]  brownout_level_cfg,
  input  wire logic        sleep_active,
  input  wire logic        supply_low,
  input  wire logic        por_event,
  output logic             brownout_detect_en,
  output logic [1:0]       brownout_threshold,
  output logic             brownout_reset_req,
  output logic             irq
);

  // ****************************************************************
  // State and next values
  // ****************************************************************
  logic        sw_enable,  next_sw_enable;
  logic        bor_flag,   next_bor_flag;
  logic        por_flag,   next_por_flag;
  logic [1:0]  irq_status, next_irq_status;
  logic [1:0]  irq_mask,   next_irq_mask;
  logic        aw_held,    next_aw_held;
  logic        w_held,     next_w_held;
  logic [3:0]  wr_addr,    next_wr_addr;
  logic [31:0] wr_data,    next_wr_data;
  logic [3:0]  wr_strb,    next_wr_strb;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        next_detect_en, next_reset_req, next_irq;
  logic [1:0]  next_threshold;
  logic        bor_event, do_write;
  logic [31:0] rd_word;
  logic        rd_hit;

  brownout_ctrl_if ctl ();

  assign ctl.mode         = brownout_mode_cfg;
  assign ctl.sw_enable    = sw_enable;
  assign ctl.sleep_active = sleep_active;

  brownout_enable_gate u_gate (
    .ctl (ctl.gate)
  );

  // ****************************************************************
  // Detection path
  // ****************************************************************

  // Reset request and event use the registered enable so the flag and request agree
  always_comb begin
    bor_event      = brownout_detect_en && supply_low;
    next_detect_en = ctl.detect_on;
    next_reset_req = bor_event;
    next_threshold = brownout_level_cfg;
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************

  // Write happens once address and data are both held; flags clear by writing zero
  always_comb begin
    do_write        = aw_held && w_held && !bvalid;
    next_sw_enable  = sw_enable;
    next_bor_flag   = bor_flag;
    next_por_flag   = por_flag;
    next_irq_status = irq_status;
    next_irq_mask   = irq_mask;
    next_bresp      = bresp;
    if (do_write) begin
      next_bresp = brownout_pkg::RESP_OKAY;
      case (wr_addr)
        brownout_pkg::RESET_CTRL_OFS: begin
          if (wr_strb[1]) begin
            next_sw_enable = wr_data[brownout_pkg::SW_ENABLE_BIT];
          end
          if (wr_strb[0]) begin
            next_bor_flag = wr_data[brownout_pkg::BOR_FLAG_BIT];
            next_por_flag = wr_data[brownout_pkg::POR_FLAG_BIT];
          end
        end
        brownout_pkg::CONFIG_OFS: ;
        brownout_pkg::IRQ_STATUS_OFS: begin
          if (wr_strb[0]) begin
            next_irq_status = irq_status & ~wr_data[1:0];
          end
        end
        brownout_pkg::IRQ_MASK_OFS: begin
          if (wr_strb[0]) begin
            next_irq_mask = wr_data[1:0];
          end
        end
        default: next_bresp = brownout_pkg::RESP_SLVERR;
      endcase
    end
    // Hardware sets after the software clear so a same-cycle event survives
    if (por_event) begin
      next_por_flag = 1'b1;
      next_irq_status[brownout_pkg::IRQ_POR_BIT] = 1'b1;
    end
    if (brownout_detect_en && (por_event || supply_low)) begin
      next_bor_flag = 1'b1;
    end
    if (bor_event) begin
      next_irq_status[brownout_pkg::IRQ_BOR_BIT] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // ****************************************************************
  // AXI4-Lite handshakes
  // ****************************************************************

  // Each channel is taken once and held until the write happens; no new one is taken until the response leaves
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid  = bvalid;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held  = 1'b1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
  end

  // Read data is captured at the address handshake; enable reads 0 outside software mode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (araddr)
      brownout_pkg::RESET_CTRL_OFS: begin
        rd_word[brownout_pkg::SW_ENABLE_BIT] =
          sw_enable && (brownout_mode_cfg == brownout_pkg::MODE_SOFTWARE);
        rd_word[brownout_pkg::BOR_FLAG_BIT] = bor_flag;
        rd_word[brownout_pkg::POR_FLAG_BIT] = por_flag;
      end
      brownout_pkg::CONFIG_OFS: begin
        rd_word[brownout_pkg::CFG_MODE_LSB +: 2]  = brownout_mode_cfg;
        rd_word[brownout_pkg::CFG_LEVEL_LSB +: 2] = brownout_level_cfg;
      end
      brownout_pkg::IRQ_STATUS_OFS: rd_word[1:0] = irq_status;
      brownout_pkg::IRQ_MASK_OFS:   rd_word[1:0] = irq_mask;
      default:                      rd_hit = 1'b0;
    endcase
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? brownout_pkg::RESP_OKAY : brownout_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Synchronous active-low reset; all outputs come straight from these flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_enable          <= brownout_pkg::SW_ENABLE_RST;
      bor_flag           <= brownout_pkg::FLAG_RST;
      por_flag           <= brownout_pkg::FLAG_RST;
      irq_status         <= brownout_pkg::IRQ_RST;
      irq_mask           <= brownout_pkg::IRQ_RST;
      aw_held            <= 1'b0;
      w_held             <= 1'b0;
      wr_addr            <= 4'h0;
      wr_data            <= 32'h0000_0000;
      wr_strb            <= 4'h0;
      awready            <= 1'b0;
      wready             <= 1'b0;
      bvalid             <= 1'b0;
      bresp              <= brownout_pkg::RESP_OKAY;
      arready            <= 1'b0;
      rvalid             <= 1'b0;
      rdata              <= 32'h0000_0000;
      rresp              <= brownout_pkg::RESP_OKAY;
      brownout_detect_en <= 1'b0;
      brownout_threshold <= brownout_pkg::LEVEL_RST;
      brownout_reset_req <= 1'b0;
      irq                <= 1'b0;
    end else begin
      sw_enable          <= next_sw_enable;
      bor_flag           <= next_bor_flag;
      por_flag           <= next_por_flag;
      irq_status         <= next_irq_status;
      irq_mask           <= next_irq_mask;
      aw_held            <= next_aw_held;
      w_held             <= next_w_held;
      wr_addr            <= next_wr_addr;
      wr_data            <= next_wr_data;
      wr_strb            <= next_wr_strb;
      awready            <= next_awready;
      wready             <= next_wready;
      bvalid             <= next_bvalid;
      bresp              <= next_bresp;
      arready            <= next_arready;
      rvalid             <= next_rvalid;
      rdata              <= next_rdata;
      rresp              <= next_rresp;
      brownout_detect_en <= next_detect_en;
      brownout_threshold <= next_threshold;
      brownout_reset_req <= next_reset_req;
      irq                <= next_irq;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  sequence s_low_seen;
    brownout_detect_en && supply_low;
  endsequence

  sequence s_request_then_flag;
    brownout_reset_req && bor_flag;
  endsequence

  property p_sw_on;
    @(posedge aclk) disable iff (!aresetn)
    (brownout_mode_cfg == brownout_pkg::MODE_SOFTWARE) && sw_enable |=> brownout_detect_en;
  endproperty
  a_sw_on: assert property (p_sw_on) else $error("software enable did not act");

  property p_sw_off;
    @(posedge aclk) disable iff (!aresetn)
    (brownout_mode_cfg == brownout_pkg::MODE_SOFTWARE) && !sw_enable |=> !brownout_detect_en;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("cleared enable left it on");

  property p_sw_reads_zero;
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready && (araddr == brownout_pkg::RESET_CTRL_OFS) &&
      (brownout_mode_cfg != brownout_pkg::MODE_SOFTWARE)
      |=> rvalid && !rdata[brownout_pkg::SW_ENABLE_BIT];
  endproperty
  a_sw_reads_zero: assert property (p_sw_reads_zero) else $error("enable bit set");

  property p_level;
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> brownout_threshold == $past(brownout_level_cfg);
  endproperty
  a_level: assert property (p_level) else $error("threshold not from level config");

  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn)
    brownout_detect_en && (por_event || supply_low) |=> bor_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("brown-out flag not set");

  property p_sleep_off;
    @(posedge aclk) disable iff (!aresetn)
    (brownout_mode_cfg == brownout_pkg::MODE_SLEEP_OFF) && sleep_active |=> !brownout_detect_en;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("detection on in sleep");

  property p_wake_on;
    @(posedge aclk) disable iff (!aresetn)
    (brownout_mode_cfg == brownout_pkg::MODE_SLEEP_OFF) && $fell(sleep_active)
      |=> brownout_detect_en;
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("detection off after wake");

  property p_fixed_modes;
    @(posedge aclk) disable iff (!aresetn)
    brownout_mode_cfg[1] == brownout_mode_cfg[0]
      |=> brownout_detect_en == $past(brownout_mode_cfg[0]);
  endproperty
  a_fixed_modes: assert property (p_fixed_modes) else $error("fixed mode wrong");

  property p_request;
    @(posedge aclk) disable iff (!aresetn)
    s_low_seen |=> s_request_then_flag;
  endproperty
  a_request: assert property (p_request) else $error("no request on supply low");

endmodule // brownout_reset_control

// ===== hw/brownout_pkg.sv
package brownout_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] RESET_CTRL_OFS = 4'h0;  // reset_control_reg
  localparam logic [3:0] CONFIG_OFS     = 4'h4;  // Read-only view of configuration
  localparam logic [3:0] IRQ_STATUS_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS   = 4'hC;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SW_ENABLE_BIT = 13;  // sw_brownout_enable in reset_control_reg
  localparam int BOR_FLAG_BIT  = 1;   // brownout_flag in reset_control_reg
  localparam int POR_FLAG_BIT  = 0;   // Power-on flag in reset_control_reg
  localparam int CFG_MODE_LSB  = 0;   // brownout_mode_cfg in config view
  localparam int CFG_LEVEL_LSB = 4;   // brownout_level_cfg in config view
  localparam int IRQ_BOR_BIT   = 0;   // Brown-out reset event
  localparam int IRQ_POR_BIT   = 1;   // Power-on reset event

  // ****************************************************************
  // Mode encodings and reset values
  // ****************************************************************
  localparam logic [1:0] MODE_OFF       = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE  = 2'h1;
  localparam logic [1:0] MODE_SLEEP_OFF = 2'h2;
  localparam logic [1:0] MODE_HARDWARE  = 2'h3;

  localparam logic        SW_ENABLE_RST = 1'b0;
  localparam logic        FLAG_RST      = 1'b0;
  localparam logic [1:0]  LEVEL_RST     = 2'h0;
  localparam logic [1:0]  IRQ_RST       = 2'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ===== hw/brownout_ctrl_if.sv
`timescale 1ns/1ps
interface brownout_ctrl_if;
  logic [1:0] mode;
  logic       sw_enable;
  logic       sleep_active;
  logic       detect_on;

  // Register side drives the controls and reads the decision
  modport regs (output mode, output sw_enable, output sleep_active, input detect_on);
  modport gate (input mode, input sw_enable, input sleep_active, output detect_on);
endinterface

// ===== hw/brownout_enable_gate.sv
`timescale 1ns/1ps
module brownout_enable_gate (
  brownout_ctrl_if.gate ctl
);

  // Mode decode: pure logic, the caller registers the result
  always_comb begin
    case (ctl.mode)
      brownout_pkg::MODE_SOFTWARE:  ctl.detect_on = ctl.sw_enable;
      brownout_pkg::MODE_SLEEP_OFF: ctl.detect_on = !ctl.sleep_active;
      brownout_pkg::MODE_HARDWARE:  ctl.detect_on = 1'b1;
      default:                      ctl.detect_on = 1'b0;
    endcase
  end

endmodule // brownout_enable_gate

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        aclk;
  logic        aresetn;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [1:0]  mode_cfg;
  logic [1:0]  level_cfg;
  logic        sleep_active;
  logic        supply_low;
  logic        por_event;
  logic        detect_en;
  logic [1:0]  threshold;
  logic        reset_req;
  logic        irq;
  logic [31:0] rd;
  int          miscompares;
  int          n_compared;

  brownout_reset_control dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .brownout_mode_cfg(mode_cfg), .brownout_level_cfg(level_cfg),
    .sleep_active(sleep_active), .supply_low(supply_low), .por_event(por_event),
    .brownout_detect_en(detect_en), .brownout_threshold(threshold),
    .brownout_reset_req(reset_req), .irq(irq)
  );

  // ****************************************************************
  // Compare and closing tasks
  // ****************************************************************
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // AXI4-Lite master tasks
  // ****************************************************************
  // Both channels offered together; each dropped only at its own handshake edge
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // No cycle count assumed here: only the watchdog ends a stuck wait
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    cmp_word({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    // Data is taken at the edge where rvalid is first seen high
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    cmp_word({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask

  // Settle a changed input: the registered outputs need one edge to show it
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  function automatic logic exp_det(input logic [1:0] m, input logic sw, input logic slp);
    case (m)
      2'h1:    return sw;
      2'h2:    return !slp;
      2'h3:    return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Clock, watchdog, tests
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // The whole sequence takes well under two thousand cycles
  initial begin
    wait_cyc(20000);
    miscompares++;
    end_of_test();
  end

  initial begin
    miscompares = 0;
    n_compared  = 0;
    aresetn <= 1'b0;  awaddr <= 4'h0;  awvalid <= 1'b0;  wdata <= 32'h0;  wstrb <= 4'h0;
    wvalid <= 1'b0;  bready <= 1'b0;  araddr <= 4'h0;  arvalid <= 1'b0;  rready <= 1'b0;
    mode_cfg <= 2'h0;  level_cfg <= 2'h0;  sleep_active <= 1'b0;  supply_low <= 1'b0;
    por_event <= 1'b0;
    wait_cyc(10);
    aresetn <= 1'b1;
    axi_read(brownout_pkg::RESET_CTRL_OFS, brownout_pkg::RESP_OKAY, rd);
    cmp_word(rd, 32'h0);
    // Every mode against both enable values; the bit is stored but masked outside 01
    for (int m = 0; m < 4; m++) begin
      mode_cfg <= m[1:0];
      for (int sw = 0; sw < 2; sw++) begin
        axi_write(brownout_pkg::RESET_CTRL_OFS, {18'h0, sw[0], 13'h0}, 4'h2,
                  brownout_pkg::RESP_OKAY);
        wait_cyc(3);
        cmp_bit(detect_en, exp_det(m[1:0], sw[0], 1'b0));
        axi_read(brownout_pkg::RESET_CTRL_OFS, brownout_pkg::RESP_OKAY, rd);
        cmp_bit(rd[13], (m == 1) && (sw == 1));
      end
    end
    // Sleep gating in mode 10, entering and leaving twice
    mode_cfg <= brownout_pkg::MODE_SLEEP_OFF;
    for (int k = 0; k < 4; k++) begin
      sleep_active <= k[0] ? 1'b0 : 1'b1;
      wait_cyc(2);
      cmp_bit(detect_en, k[0]);
    end
    // Threshold ignores writes to both the control word and the config view
    for (int lv = 0; lv < 4; lv++) begin
      level_cfg <= lv[1:0];
      axi_write(brownout_pkg::RESET_CTRL_OFS, 32'hFFFFFFFF, 4'hF, brownout_pkg::RESP_OKAY);
      axi_write(brownout_pkg::CONFIG_OFS, 32'hFFFFFFFF, 4'hF, brownout_pkg::RESP_OKAY);
      cmp_word({30'h0, threshold}, {30'h0, lv[1:0]});
      axi_read(brownout_pkg::CONFIG_OFS, brownout_pkg::RESP_OKAY, rd);
      cmp_word(rd, {26'h0, lv[1:0], 2'h0, 2'h2});
    end
    // Flags in hardware mode: power-on sets both, a low supply sets only brown-out
    mode_cfg <= brownout_pkg::MODE_HARDWARE;
    axi_write(brownout_pkg::RESET_CTRL_OFS, 32'h0, 4'h1, brownout_pkg::RESP_OKAY);
    axi_write(brownout_pkg::IRQ_STATUS_OFS, 32'h3, 4'h1, brownout_pkg::RESP_OKAY);
    @(posedge aclk) por_event <= 1'b1;
    @(posedge aclk) por_event <= 1'b0;
    axi_read(brownout_pkg::RESET_CTRL_OFS, brownout_pkg::RESP_OKAY, rd);
    cmp_word(rd & 32'h3, 32'h3);
    axi_write(brownout_pkg::RESET_CTRL_OFS, 32'h0, 4'h1, brownout_pkg::RESP_OKAY);
    axi_write(brownout_pkg::IRQ_MASK_OFS, 32'h1, 4'h1, brownout_pkg::RESP_OKAY);
    @(posedge aclk) supply_low <= 1'b1;
    wait_cyc(3);
    cmp_bit(reset_req, 1'b1);
    supply_low <= 1'b0;
    wait_cyc(3);
    cmp_bit(reset_req, 1'b0);
    cmp_bit(irq, 1'b1);
    axi_read(brownout_pkg::RESET_CTRL_OFS, brownout_pkg::RESP_OKAY, rd);
    cmp_word(rd & 32'h3, 32'h2);
    // Interrupt: mask off, mask on, then clear by writing one
    axi_write(brownout_pkg::IRQ_MASK_OFS, 32'h0, 4'h1, brownout_pkg::RESP_OKAY);
    wait_cyc(2);
    cmp_bit(irq, 1'b0);
    axi_read(brownout_pkg::IRQ_STATUS_OFS, brownout_pkg::RESP_OKAY, rd);
    cmp_word(rd, 32'h3);
    axi_write(brownout_pkg::IRQ_MASK_OFS, 32'h3, 4'h1, brownout_pkg::RESP_OKAY);
    wait_cyc(2);
    cmp_bit(irq, 1'b1);
    axi_write(brownout_pkg::IRQ_STATUS_OFS, 32'h3, 4'h1, brownout_pkg::RESP_OKAY);
    wait_cyc(2);
    cmp_bit(irq, 1'b0);
    // Detection off: power-on sets only its own flag and a low supply is ignored
    mode_cfg <= brownout_pkg::MODE_OFF;
    axi_write(brownout_pkg::RESET_CTRL_OFS, 32'h0, 4'h1, brownout_pkg::RESP_OKAY);
    @(posedge aclk) por_event <= 1'b1;
    @(posedge aclk) por_event <= 1'b0;
    supply_low <= 1'b1;
    wait_cyc(3);
    cmp_bit(reset_req, 1'b0);
    supply_low <= 1'b0;
    axi_read(brownout_pkg::RESET_CTRL_OFS, brownout_pkg::RESP_OKAY, rd);
    cmp_word(rd & 32'h3, 32'h1);
    // Unmapped place answers with an error and reads zero
    axi_write(4'h2, 32'hFFFFFFFF, 4'hF, brownout_pkg::RESP_SLVERR);
    axi_read(4'h2, brownout_pkg::RESP_SLVERR, rd);
    cmp_word(rd, 32'h0);
    end_of_test();
  end
endmodule  // testbench
